// ---- dv/ewg_unlock_props.sv ----
// checker for the unlock flag, its read-back and the eeprom write gate
// assumes binding onto ewg_unlock; sees only its ports
`default_nettype none
module ewg_unlock_props
  import ewg_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        reset_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        ee_wr_req_in,
  input wire logic        ee_busy_in,
  input wire logic        ee_wr_strobe_out,
  input wire logic        ee_write_enable_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_acc;
    psel_in && penable_in && pready_out && paddr_in == EWG_UNLOCK_ADDR;
  endsequence
  sequence s_key;
    s_acc ##0 (pwrite_in && pwdata_in[7:0] == EWG_UNLOCK_KEY);
  endsequence
  property p_set; s_key |=> ee_write_enable_out; endproperty
  property p_clr;
    s_acc ##0 (pwrite_in && pwdata_in[7:0] != EWG_UNLOCK_KEY) |=> !ee_write_enable_out;
  endproperty
  // flag moves only on a completed apb write
  property p_keep;
    !(psel_in && penable_in && pready_out && pwrite_in) |=> $stable(ee_write_enable_out);
  endproperty
  property p_rd; s_acc ##0 !pwrite_in |-> prdata_out[EWG_ENABLE_BIT] == ee_write_enable_out;
  endproperty
  property p_to;
    s_acc ##0 (!pwrite_in && !ee_write_enable_out) |-> !prdata_out[EWG_TIMEOUT_BIT];
  endproperty
  property p_blk; ee_wr_req_in && !ee_write_enable_out |=> !ee_wr_strobe_out; endproperty
  property p_acc;
    ee_wr_req_in && ee_write_enable_out && !ee_busy_in |=> ee_wr_strobe_out;
  endproperty
  a_set: assert property (p_set) else $error("key write left flag clear");
  a_clr: assert property (p_clr) else $error("other write left flag set");
  a_keep: assert property (p_keep) else $error("flag moved without write");
  a_rd: assert property (p_rd) else $error("bit 5 differs from flag");
  a_to: assert property (p_to) else $error("time-out bit set while disarmed");
  a_blk: assert property (p_blk) else $error("write passed while disarmed");
  a_acc: assert property (p_acc) else $error("armed write not passed");
endmodule : ewg_unlock_props
bind ewg_unlock ewg_unlock_props i_props (.*);
`default_nettype wire

// ---- dv/tb_eeprom_write_unlock_gate.sv ----
// self-checking bench for the eeprom write unlock register
// assumes ewg_unlock as top; this bench is apb master and eeprom core
`default_nettype none
module tb_eeprom_write_unlock_gate
  import ewg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        req = 1'b0, busy = 1'b0, pready, perr, irq, stb, wen;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [7:0]  eaddr = 8'h00, edata = 8'h00, eaddr_o, edata_o;
  logic [32:0] exp_q[$];
  int          n_errors = 0, total_checks = 0, seed = 32'h5f1d, i;
  always #50 clk = ~clk;
  // short time-out keeps the run brief
  ewg_unlock #(.TIMEOUT_CYCLES(4)) i_dut (.core_clk_in(clk), .reset_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .irq_out(irq),
    .ee_wr_req_in(req), .ee_wr_addr_in(eaddr), .ee_wr_data_in(edata), .ee_busy_in(busy),
    .ee_wr_strobe_out(stb), .ee_wr_addr_out(eaddr_o), .ee_wr_data_out(edata_o),
    .ee_write_enable_out(wen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      finish_test();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // request, then strobe looked at in the cycle it stands
  task automatic ee(input logic ok);
    @(posedge clk);
    req <= 1'b1;
    eaddr <= 8'($random(seed));
    edata <= 8'($random(seed));
    @(posedge clk);
    req <= 1'b0;
    #1 chk(33'(stb), 33'(ok));
    if (ok) chk(33'({eaddr_o, edata_o}), 33'({eaddr, edata}));
  endtask : ee
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    #1 chk(33'(irq), 33'(e));
  endtask : irq_chk
  // read watcher: oldest note against each completed read
  always @(posedge clk) begin
    if (psel && pen && !pwr && pready === 1'b1) begin
      if (exp_q.size() == 0) chk({perr, prdata}, 33'h0FFFFFFFF);
      else chk({perr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(EWG_UNLOCK_ADDR, 33'h0);
    rd(EWG_IRQ_STATUS_ADDR, 33'h0);
    rd(EWG_IRQ_MASK_ADDR, 33'h0);
    rd(12'h008, 33'h100000000);
    ee(1'b0);
    rd(EWG_IRQ_STATUS_ADDR, 33'h2);
    apb(1'b1, EWG_IRQ_MASK_ADDR, 32'h3);
    irq_chk(1'b1);
    apb(1'b1, EWG_IRQ_STATUS_ADDR, 32'h2);
    irq_chk(1'b0);
    $display("test blocked write done");
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      apb(1'b1, EWG_UNLOCK_ADDR, {d[31:8], EWG_UNLOCK_KEY});
      // enable pin settles just after the completing edge
      #1 chk(33'(wen), 33'h1);
      rd(EWG_UNLOCK_ADDR, 33'h20);
      apb(1'b1, EWG_UNLOCK_ADDR, {d[31:8], (d[7:0] == EWG_UNLOCK_KEY) ? 8'h00 : d[7:0]});
      #1 chk(33'(wen), 33'h0);
      rd(EWG_UNLOCK_ADDR, 33'h0);
    end
    $display("test arm and disarm done");
    apb(1'b1, EWG_UNLOCK_ADDR, 32'(EWG_UNLOCK_KEY));
    ee(1'b1);
    @(posedge clk);
    busy <= 1'b1;
    ee(1'b0);
    repeat (8) @(posedge clk);
    busy <= 1'b0;
    rd(EWG_UNLOCK_ADDR, 33'h60);
    rd(EWG_IRQ_STATUS_ADDR, 33'h3);
    irq_chk(1'b1);
    apb(1'b1, EWG_UNLOCK_ADDR, 32'h0);
    rd(EWG_UNLOCK_ADDR, 33'h0);
    apb(1'b1, EWG_IRQ_STATUS_ADDR, 32'h3);
    irq_chk(1'b0);
    $display("test time-out done");
    finish_test();
  end
endmodule : tb_eeprom_write_unlock_gate
`default_nettype wire

// ---- src/ewg_gate.sv ----
// write gate and engine time-out watch
// assumes req is a one-cycle pulse and busy a level from the engine
`default_nettype none
module ewg_gate
  import ewg_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = EWG_TIMEOUT_CYCLES
) (
  input  wire logic  core_clk_in,
  input  wire logic  reset_in,
  ewg_gate_if.gate   gif
);
  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LIM = CW'(TIMEOUT_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tmo;
  } ewg_gate_st_t;

  ewg_gate_st_t st_reg;
  ewg_gate_st_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // a request while the engine is busy is dropped, not queued
  assign gif.fire    = gif.req & gif.wr_en & ~gif.busy;
  assign gif.blocked = gif.req & ~(gif.wr_en & ~gif.busy);
  assign gif.tmo     = st_reg.tmo;

  always_comb begin
    st_next = st_reg;
    st_next.tmo = 1'b0;
    if (!gif.busy) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt <= LIM) begin
      st_next.cnt = st_reg.cnt + CW'(1);
      st_next.tmo = (st_reg.cnt == LIM);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : ewg_gate
`default_nettype wire

// ---- src/ewg_gate_if.sv ----
// signals between the register block and the write gate
// assumes both ends run on the core clock
`default_nettype none
interface ewg_gate_if;
  logic wr_en;
  logic req;
  logic busy;
  logic fire;
  logic blocked;
  logic tmo;
  modport regs (output wr_en, output req, output busy, input fire, input blocked, input tmo);
  modport gate (input wr_en, input req, input busy, output fire, output blocked, output tmo);
endinterface : ewg_gate_if
`default_nettype wire

// ---- src/ewg_pkg.sv ----
// constants for the eeprom write unlock gate
// assumes a 32-bit apb slave port and one core clock
`default_nettype none
package ewg_pkg;
  localparam logic [7:0]  EWG_UNLOCK_KEY       = 8'hE2;
  localparam int          EWG_UNLOCK_INDEX     = 'hC9;
  localparam logic [11:0] EWG_UNLOCK_ADDR      = 12'(EWG_UNLOCK_INDEX * 4);
  localparam logic [11:0] EWG_IRQ_STATUS_ADDR  = 12'h000;
  localparam logic [11:0] EWG_IRQ_MASK_ADDR    = 12'h004;
  localparam int          EWG_TIMEOUT_BIT      = 6;
  localparam int          EWG_ENABLE_BIT       = 5;
  localparam int          EWG_IRQ_TIMEOUT_BIT  = 0;
  localparam int          EWG_IRQ_BLOCKED_BIT  = 1;
  localparam int          EWG_IRQ_W            = 2;
  localparam logic        EWG_ENABLE_RST       = 1'b0;
  localparam int          EWG_TIMEOUT_CYCLES   = 1000;
  localparam int          EWG_EE_ADDR_W        = 8;
  localparam int          EWG_EE_DATA_W        = 8;
endpackage : ewg_pkg
`default_nettype wire

// ---- src/ewg_unlock.sv ----
// eeprom write unlock register with apb slave and interrupt
// assumes apb master on the core clock, engine busy level synchronous
`default_nettype none
module ewg_unlock
  import ewg_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = EWG_TIMEOUT_CYCLES,
  parameter int EE_ADDR_W      = EWG_EE_ADDR_W,
  parameter int EE_DATA_W      = EWG_EE_DATA_W
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [11:0]          paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output var  logic [31:0]          prdata_out,
  output var  logic                 pready_out,
  output var  logic                 pslverr_out,
  output var  logic                 irq_out,
  input  wire logic                 ee_wr_req_in,
  input  wire logic [EE_ADDR_W-1:0] ee_wr_addr_in,
  input  wire logic [EE_DATA_W-1:0] ee_wr_data_in,
  input  wire logic                 ee_busy_in,
  output var  logic                 ee_wr_strobe_out,
  output var  logic [EE_ADDR_W-1:0] ee_wr_addr_out,
  output var  logic [EE_DATA_W-1:0] ee_wr_data_out,
  output var  logic                 ee_write_enable_out
);
  generate
    if (TIMEOUT_CYCLES < 1 || EE_ADDR_W < 1 || EE_DATA_W < 1) begin : g_bad
      $error("ewg_unlock: parameter out of range");
    end
  endgenerate

  typedef struct packed {
    logic                 we;
    logic                 tmo_flag;
    logic [EWG_IRQ_W-1:0] irq_sts;
    logic [EWG_IRQ_W-1:0] irq_msk;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic                 irq;
    logic                 strobe;
    logic [EE_ADDR_W-1:0] addr;
    logic [EE_DATA_W-1:0] data;
  } ewg_st_t;

  ewg_st_t st_reg;
  ewg_st_t st_next;

  ewg_gate_if gif ();

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == EWG_UNLOCK_ADDR) || (a == EWG_IRQ_STATUS_ADDR) || (a == EWG_IRQ_MASK_ADDR);
  endfunction : addr_ok

  assign gif.wr_en = st_reg.we;
  assign gif.req   = ee_wr_req_in;
  assign gif.busy  = ee_busy_in;

  ewg_gate #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_gate (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .gif         (gif.gate)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic                 access;
  logic                 done;
  logic [EWG_IRQ_W-1:0] ev;
  logic [EWG_IRQ_W-1:0] w1c;

  always_comb begin
    st_next = st_reg;
    access  = psel_in & penable_in;
    done    = access & st_reg.pready;
    ev      = '0;
    w1c     = '0;
    ev[EWG_IRQ_TIMEOUT_BIT] = gif.tmo & st_reg.we;
    ev[EWG_IRQ_BLOCKED_BIT] = gif.blocked;

    // one wait state: pready rises on the second access cycle
    st_next.pready  = access & ~st_reg.pready;
    st_next.pslverr = access & ~st_reg.pready & ~addr_ok(paddr_in);
    st_next.prdata  = '0;
    if (access && !st_reg.pready && !pwrite_in) begin
      unique case (paddr_in)
        EWG_UNLOCK_ADDR: begin
          st_next.prdata[EWG_TIMEOUT_BIT] = st_reg.tmo_flag;
          st_next.prdata[EWG_ENABLE_BIT]  = st_reg.we;
        end
        EWG_IRQ_STATUS_ADDR: st_next.prdata[EWG_IRQ_W-1:0] = st_reg.irq_sts;
        EWG_IRQ_MASK_ADDR:   st_next.prdata[EWG_IRQ_W-1:0] = st_reg.irq_msk;
        default:             st_next.prdata = '0;
      endcase
    end

    if (done && pwrite_in) begin
      unique case (paddr_in)
        EWG_UNLOCK_ADDR:     st_next.we = (pwdata_in[7:0] == EWG_UNLOCK_KEY);
        EWG_IRQ_STATUS_ADDR: w1c = pwdata_in[EWG_IRQ_W-1:0];
        EWG_IRQ_MASK_ADDR:   st_next.irq_msk = pwdata_in[EWG_IRQ_W-1:0];
        default:             w1c = '0;
      endcase
    end

    // time-out seen only while armed; cleared as soon as armed drops
    if (!st_next.we) begin
      st_next.tmo_flag = 1'b0;
    end else if (ev[EWG_IRQ_TIMEOUT_BIT]) begin
      st_next.tmo_flag = 1'b1;
    end

    // set beats clear when both land in one cycle
    st_next.irq_sts = (st_reg.irq_sts & ~w1c) | ev;
    st_next.irq     = |(st_next.irq_sts & st_next.irq_msk);

    st_next.strobe = gif.fire;
    if (gif.fire) begin
      st_next.addr = ee_wr_addr_in;
      st_next.data = ee_wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_reg    <= '0;
      st_reg.we <= EWG_ENABLE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata_out          = st_reg.prdata;
  assign pready_out          = st_reg.pready;
  assign pslverr_out         = st_reg.pslverr;
  assign irq_out             = st_reg.irq;
  assign ee_wr_strobe_out    = st_reg.strobe;
  assign ee_wr_addr_out      = st_reg.addr;
  assign ee_wr_data_out      = st_reg.data;
  assign ee_write_enable_out = st_reg.we;
endmodule : ewg_unlock
`default_nettype wire
